//--- tb_top.sv
/* tb_top: self-checking bench for the trinary remote code link.
   assumes trit_word_sender as far encoder and shortened encoder timing. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int ENC = 4;
    logic        sys_clk, resetn, req_n, sel_enc, ser_out, busy, p_line, valid;
    logic [17:0] code, laddr;
    logic [8:0]  pin_in;
    wire  [8:0]  pin_out, pin_oe_n;
    logic [3:0]  nib;
    int          failures, n_checks, cyc, rises;
    // strongly tied pins win, open pins follow the weak probe
    for (genvar k = 0; k < 9; k++) begin : g_pin
        assign pin_in[k] = (code[2*k+:2] == 2'h2) ? (pin_oe_n[k] | pin_out[k]) : code[2*k];
    end
    trinary_remote_code_link #(.ENC_CLK_CYC(ENC), .SETTLE_CYC(2)) i_trinary_remote_code_link (
        .sys_clk(sys_clk), .resetn(resetn), .transmit_request_n(req_n),
        .address_trit_inputs_in(pin_in[4:0]), .address_trit_inputs_out(pin_out[4:0]),
        .address_trit_inputs_oe_n(pin_oe_n[4:0]), .address_or_data_trit_inputs_in(pin_in[8:5]),
        .address_or_data_trit_inputs_out(pin_out[8:5]), .address_or_data_trit_inputs_oe_n(pin_oe_n[8:5]),
        .serial_out(ser_out), .encoder_busy(busy), .serial_in(sel_enc ? ser_out : p_line),
        .local_address(laddr), .decoded_nibble_outputs(nib), .valid_word_flag(valid));
    trit_word_sender #(.ENC(ENC)) i_trit_word_sender (.sys_clk(sys_clk), .line(p_line));
    always @(posedge ser_out) rises++;
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // short request: one pair looped back, then silence
    task automatic t_enc_pair();
        int dur, hs = 0, r0 = rises;
        code <= 18'h0_4864;
        laddr <= 18'h0_4864;
        @(posedge sys_clk);
        req_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        req_n <= 1'b1;
        for (int i = 0; i < 4000 && valid !== 1'b1; i++) @(negedge sys_clk);
        chk(16'(valid), 16'h0001);
        chk(16'(nib), 16'h0005);
        chk(16'(rises - r0), 16'h0024);
        for (dur = 0; dur < 600 && valid === 1'b1; dur++) @(negedge sys_clk);
        chk(16'(dur >= 124 && dur <= 134), 16'h0001);
        chk(16'(nib), 16'h0005);
        repeat (200) @(negedge sys_clk) hs += int'(ser_out !== 1'b0 || busy !== 1'b0);
        chk(16'(hs), 16'h0000);
    endtask
    // far encoder: data mismatch, wrong address, then a good pair
    task automatic t_far_words();
        sel_enc <= 1'b0;
        @(posedge sys_clk);
        i_trit_word_sender.send_word(18'h0_4864);
        i_trit_word_sender.send_word(18'h2_1464);
        chk(16'({valid, nib}), 16'h0005);
        i_trit_word_sender.send_word(18'h2_1465);
        i_trit_word_sender.send_word(18'h2_1464);
        chk(16'({valid, nib}), 16'h0005);
        i_trit_word_sender.send_word(18'h2_1464);
        chk(16'({valid, nib}), 16'h001b);
    endtask
    // request held low keeps words coming past one pair
    task automatic t_hold_low();
        int r0 = rises;
        sel_enc <= 1'b1;
        @(posedge sys_clk);
        req_n <= 1'b0;
        repeat (3200) @(negedge sys_clk);
        chk(16'(rises - r0 > 36), 16'h0001);
        @(posedge sys_clk);
        req_n <= 1'b1;
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge sys_clk);
        chk(16'(busy), 16'h0000);
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        resetn = 1'b0;
        req_n = 1'b1;
        sel_enc = 1'b1;
        code = 18'h0_0000;
        laddr = 18'h0_0000;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        t_enc_pair();
        t_far_words();
        t_hold_low();
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire

//--- tl_pkg.sv
/*
  tl_pkg: constants shared by the trinary code encoder and decoder.
  assumes a 100 MHz sys_clk and matching settings on both link ends.
*/
package tl_pkg;
    localparam int SYS_CLK_NS   = 10;
    // encoder clock period, plain default, same on both ends
    localparam int ENC_CLK_NS   = 10_000;
    localparam int ENC_CLK_CYC  = ENC_CLK_NS / SYS_CLK_NS;
    // bit slot and pulse widths in encoder clocks
    localparam int BIT_CLKS     = 8;
    localparam int SHORT_CLKS   = 1;
    localparam int LONG_CLKS    = 3;
    // one data period carries one trit as two bit slots
    localparam int PERIOD_CLKS  = 2 * BIT_CLKS;
    localparam int GAP_PERIODS  = 3;
    localparam int EOW_PERIODS  = 2;
    localparam int EOT_PERIODS  = 4;
    // short/long decision point, hundredths of an encoder clock
    localparam int THRESH_X100  = 172;
    // weak drive settling time before a pin is read
    localparam int SETTLE_NS    = 1_000;
    localparam int SETTLE_CYC   = (SETTLE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int WORD_TRITS   = 9;
    localparam int ADDR_TRITS   = 5;
    localparam int NIB_BITS     = 4;
    localparam int CNT_W        = 24;
    typedef logic [CNT_W-1:0] cnt_t;
    typedef logic [1:0]       trit_t;
    localparam trit_t TRIT_LOW  = 2'h0;
    localparam trit_t TRIT_HIGH = 2'h1;
    localparam trit_t TRIT_OPEN = 2'h2;
endpackage

//--- trinary_remote_code_link.sv
/*
  trinary_remote_code_link: encoder end (instance) and decoder end of a
  one-wire trinary remote code link. ADDR_ONLY selects the nine-address
  decoder; otherwise five address trits and a four-bit data nibble.
  assumes serial_in, local_address and code pins are raw pins.
*/
// Behaviour
// - nine code inputs, each low high open
// - low transmit request starts sending
// - request held low repeats words continuously
// - short request pulse sends one pair
// - three idle data periods between words
// - trit pulses: low SS, high LL, open LS
// - classify pins by weak high/low forcing
// - request high at pair end: encoder idle, line quiet
// - sense pins in order, then shift out
// - first five trits compared with address
// - first match stores nibble, output unchanged
// - second word address must match again
// - second nibble compared with stored nibble
// - equal nibbles load and hold output latch
// - valid flag rises at latch, holds
// - four silent periods drop valid flag
// - open data trit decodes as one
// - address-only variant compares all nine trits
// - address-only needs two matching words
// - binary levels give 512 nine-position codes
// - short/long threshold 1.72 encoder clocks
// - two low data periods end word
// - transmit request active low, idles high
`timescale 1ns/10ps
`default_nettype none
module trinary_remote_code_link #(
    parameter bit ADDR_ONLY   = 1'b0,
    parameter int ENC_CLK_CYC = tl_pkg::ENC_CLK_CYC,
    parameter int SETTLE_CYC  = tl_pkg::SETTLE_CYC
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // encoder request
    input  wire logic        transmit_request_n,
    // encoder code pins, position 1 in bit 0
    input  wire logic [4:0]  address_trit_inputs_in,
    output logic      [4:0]  address_trit_inputs_out,
    output logic      [4:0]  address_trit_inputs_oe_n,
    input  wire logic [3:0]  address_or_data_trit_inputs_in,
    output logic      [3:0]  address_or_data_trit_inputs_out,
    output logic      [3:0]  address_or_data_trit_inputs_oe_n,
    // encoder serial line
    output logic             serial_out,
    output logic             encoder_busy,
    // decoder serial line and local address, two bits per trit
    input  wire logic        serial_in,
    input  wire logic [17:0] local_address,
    // decoder results
    output logic      [3:0]  decoded_nibble_outputs,
    output logic             valid_word_flag
);
    localparam int AW = ADDR_ONLY ? tl_pkg::WORD_TRITS : tl_pkg::ADDR_TRITS;
    localparam int PCYC = tl_pkg::PERIOD_CLKS * ENC_CLK_CYC;
    localparam tl_pkg::cnt_t THRESH  =
        tl_pkg::cnt_t'((ENC_CLK_CYC * tl_pkg::THRESH_X100 + 50) / 100);
    localparam tl_pkg::cnt_t EOW_CYC = tl_pkg::cnt_t'(tl_pkg::EOW_PERIODS * PCYC);
    localparam tl_pkg::cnt_t EOT_CYC = tl_pkg::cnt_t'(tl_pkg::EOT_PERIODS * PCYC);
    localparam logic [3:0]   NTRITS  = 4'(tl_pkg::WORD_TRITS);

    logic [8:0] enc_out, enc_oe_n;

    // encoder end
    trit_encoder #(
        .ENC_CLK_CYC (ENC_CLK_CYC),
        .SETTLE_CYC  (SETTLE_CYC)
    ) u_enc (
        .sys_clk            (sys_clk),
        .resetn             (resetn),
        .transmit_request_n (transmit_request_n),
        .code_pin_in        ({address_or_data_trit_inputs_in, address_trit_inputs_in}),
        .code_pin_out       (enc_out),
        .code_pin_oe_n      (enc_oe_n),
        .serial_out         (serial_out),
        .busy               (encoder_busy)
    );

    assign address_trit_inputs_out          = enc_out[4:0];
    assign address_trit_inputs_oe_n         = enc_oe_n[4:0];
    assign address_or_data_trit_inputs_out  = enc_out[8:5];
    assign address_or_data_trit_inputs_oe_n = enc_oe_n[8:5];

    // decoder input synchronisers
    logic [2:0]  din_s_reg, din_s_next;
    logic        din_reg, din_next;
    logic [17:0] la_s1_reg, la_s2_reg, la_s3_reg, la_reg, la_next;

    always_comb begin
        din_s_next = {din_s_reg[1:0], serial_in};
        din_next   = (din_s_reg[1] == din_s_reg[2]) ? din_s_reg[2] : din_reg;
        la_next    = (la_s2_reg & la_s3_reg) | (la_reg & (la_s2_reg ^ la_s3_reg));
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            din_s_reg <= 3'h0;
            din_reg   <= 1'h0;
            la_s1_reg <= 18'h0_0000;
            la_s2_reg <= 18'h0_0000;
            la_s3_reg <= 18'h0_0000;
            la_reg    <= 18'h0_0000;
        end else begin
            din_s_reg <= din_s_next;
            din_reg   <= din_next;
            la_s1_reg <= local_address;
            la_s2_reg <= la_s1_reg;
            la_s3_reg <= la_s2_reg;
            la_reg    <= la_next;
        end
    end

    // decoder state
    tl_pkg::cnt_t        hi_cnt_reg, hi_cnt_next;
    tl_pkg::cnt_t        lo_cnt_reg, lo_cnt_next;
    logic                half_reg, half_next;
    logic                first_reg, first_next;
    logic [3:0]          tcnt_reg, tcnt_next;
    logic                err_reg, err_next;
    tl_pkg::trit_t [8:0] trits_reg, trits_next;
    logic                have_reg, have_next;
    logic [3:0]          stored_reg, stored_next;
    logic [3:0]          nib_next;
    logic                valid_next;

    // per-position address compare and data bit extraction
    logic [8:0] pos_match;
    logic [3:0] word_nib;
    logic       addr_match;

    for (genvar i = 0; i < tl_pkg::WORD_TRITS; i++) begin : g_pos
        if (i < AW) begin : g_addr
            assign pos_match[i] = (trits_reg[i] == la_reg[2*i +: 2]);
        end else begin : g_data
            assign pos_match[i] = 1'b1;
        end
    end

    for (genvar j = 0; j < tl_pkg::NIB_BITS; j++) begin : g_nib
        // open and high both read as one
        assign word_nib[j] = (trits_reg[tl_pkg::ADDR_TRITS + j] != tl_pkg::TRIT_LOW);
    end

    assign addr_match = &pos_match;

    logic          bit_long;
    tl_pkg::trit_t rx_trit;
    logic          rx_bad;
    logic          word_ok;
    logic          started;

    always_comb begin
        hi_cnt_next = hi_cnt_reg;
        lo_cnt_next = lo_cnt_reg;
        half_next   = half_reg;
        first_next  = first_reg;
        tcnt_next   = tcnt_reg;
        err_next    = err_reg;
        trits_next  = trits_reg;
        have_next   = have_reg;
        stored_next = stored_reg;
        nib_next    = decoded_nibble_outputs;
        valid_next  = valid_word_flag;
        bit_long    = (hi_cnt_reg >= THRESH);
        rx_trit     = tl_pkg::TRIT_LOW;
        rx_bad      = 1'b0;
        unique case ({first_reg, bit_long})
            2'h0: rx_trit = tl_pkg::TRIT_LOW;
            2'h3: rx_trit = tl_pkg::TRIT_HIGH;
            2'h2: rx_trit = tl_pkg::TRIT_OPEN;
            2'h1: rx_bad  = 1'b1;
        endcase
        started = (tcnt_reg != 4'h0) || half_reg || err_reg;
        word_ok = !err_reg && !half_reg && (tcnt_reg == NTRITS) && addr_match;
        if (din_reg) begin
            if (hi_cnt_reg != '1)
                hi_cnt_next = hi_cnt_reg + 1'b1;
            lo_cnt_next = '0;
            if (!din_next) begin
                // falling edge closes one bit slot
                if (!half_reg) begin
                    first_next = bit_long;
                    half_next  = 1'b1;
                end else begin
                    half_next = 1'b0;
                    if (rx_bad || tcnt_reg == NTRITS) begin
                        err_next = 1'b1;
                    end else begin
                        trits_next[tcnt_reg] = rx_trit;
                        tcnt_next            = tcnt_reg + 4'h1;
                    end
                end
            end
        end else begin
            hi_cnt_next = '0;
            if (lo_cnt_reg != EOT_CYC)
                lo_cnt_next = lo_cnt_reg + 1'b1;
            if (lo_cnt_reg == EOW_CYC - 1'b1 && started) begin
                tcnt_next = 4'h0;
                half_next = 1'b0;
                err_next  = 1'b0;
                if (!word_ok) begin
                    // a bad or partial word, such as one cut at power-up
                    have_next  = 1'b0;
                    valid_next = 1'b0;
                end else if (!have_reg) begin
                    have_next   = 1'b1;
                    stored_next = word_nib;
                end else if (ADDR_ONLY || word_nib == stored_reg) begin
                    have_next  = 1'b0;
                    valid_next = 1'b1;
                    if (!ADDR_ONLY)
                        nib_next = word_nib;
                end else begin
                    have_next  = 1'b0;
                    valid_next = 1'b0;
                end
            end
            if (lo_cnt_reg == EOT_CYC - 1'b1) begin
                valid_next = 1'b0;
                have_next  = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            hi_cnt_reg             <= '0;
            lo_cnt_reg             <= '0;
            half_reg               <= 1'h0;
            first_reg              <= 1'h0;
            tcnt_reg               <= 4'h0;
            err_reg                <= 1'h0;
            trits_reg              <= '0;
            have_reg               <= 1'h0;
            stored_reg             <= 4'h0;
            decoded_nibble_outputs <= 4'h0;
            valid_word_flag        <= 1'h0;
        end else begin
            hi_cnt_reg             <= hi_cnt_next;
            lo_cnt_reg             <= lo_cnt_next;
            half_reg               <= half_next;
            first_reg              <= first_next;
            tcnt_reg               <= tcnt_next;
            err_reg                <= err_next;
            trits_reg              <= trits_next;
            have_reg               <= have_next;
            stored_reg             <= stored_next;
            decoded_nibble_outputs <= nib_next;
            valid_word_flag        <= valid_next;
        end
    end
endmodule // trinary_remote_code_link
`default_nettype wire

//--- trinary_remote_code_link_asserts.sv
/* link_checker: port-level assertions for trinary_remote_code_link.
   assumes the bound instance's ENC_CLK_CYC and the package timing. */
`timescale 1ns/10ps
`default_nettype none
module link_checker #(
    parameter int ENC_CLK_CYC = 4
) (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       resetn,
    // watched ports
    input wire logic       transmit_request_n,
    input wire logic [4:0] address_trit_inputs_oe_n,
    input wire logic [3:0] address_or_data_trit_inputs_oe_n,
    input wire logic       serial_out,
    input wire logic       encoder_busy,
    input wire logic       serial_in,
    input wire logic [3:0] decoded_nibble_outputs,
    input wire logic       valid_word_flag
);
    localparam int SLOT = tl_pkg::BIT_CLKS * ENC_CLK_CYC;
    localparam int PER  = tl_pkg::PERIOD_CLKS * ENC_CLK_CYC;
    logic [15:0] hi_reg, hi_next, rr_reg, rr_next, lo_reg, lo_next;
    logic        so_reg, seen_reg, seen_next;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // high run, plus saturating rise-to-rise spacing and decoder-side silence
    always_comb begin
        hi_next   = serial_out ? hi_reg + 16'h0001 : 16'h0000;
        rr_next   = (serial_out && !so_reg) ? 16'h0001 : rr_reg + {15'h0000, ~&rr_reg};
        lo_next   = serial_in ? 16'h0000 : lo_reg + {15'h0000, ~&lo_reg};
        seen_next = encoder_busy && (seen_reg || (serial_out && !so_reg));
    end
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            {hi_reg, rr_reg, lo_reg, so_reg, seen_reg} <= '0;
        end else begin
            {hi_reg, rr_reg, lo_reg, so_reg, seen_reg} <= {hi_next, rr_next, lo_next, serial_out, seen_next};
        end
    end
    property p_rst_state;
        disable iff (1'b0) !resetn |=> !serial_out && !encoder_busy && !valid_word_flag
            && decoded_nibble_outputs == 4'h0;
    endproperty
    a_rst_state: assert property (p_rst_state) else $error("outputs not cleared by reset");
    property p_idle_quiet;
        !encoder_busy |-> !serial_out && &{address_trit_inputs_oe_n, address_or_data_trit_inputs_oe_n};
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("idle encoder drives a line");
    property p_one_probe;
        $countones(~{address_trit_inputs_oe_n, address_or_data_trit_inputs_oe_n}) <= 1;
    endproperty
    a_one_probe: assert property (p_one_probe) else $error("two pins probed at once");
    property p_start;
        $fell(transmit_request_n) && !encoder_busy |-> ##[3:6] encoder_busy;
    endproperty
    a_start: assert property (p_start) else $error("request did not start encoder");
    property p_pulse_width;
        $fell(serial_out) |-> hi_reg == tl_pkg::SHORT_CLKS * ENC_CLK_CYC || hi_reg == tl_pkg::LONG_CLKS * ENC_CLK_CYC;
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("serial pulse width wrong");
    property p_rise_spacing;
        $rose(serial_out) && seen_reg |-> rr_reg == SLOT || rr_reg >= SLOT + tl_pkg::GAP_PERIODS * PER;
    endproperty
    a_rise_spacing: assert property (p_rise_spacing) else $error("slot or gap spacing wrong");
    property p_eot_drop;
        lo_reg > tl_pkg::EOT_PERIODS * PER + 16 |-> !valid_word_flag;
    endproperty
    a_eot_drop: assert property (p_eot_drop) else $error("valid flag held through silence");
    property p_rise_after_word;
        $rose(valid_word_flag) |-> lo_reg >= tl_pkg::EOW_PERIODS * PER;
    endproperty
    a_rise_after_word: assert property (p_rise_after_word) else $error("valid flag rose mid word");
    property p_latch_with_flag;
        $changed(decoded_nibble_outputs) |-> valid_word_flag;
    endproperty
    a_latch_with_flag: assert property (p_latch_with_flag) else $error("nibble moved without flag");
endmodule // link_checker
bind trinary_remote_code_link link_checker #(.ENC_CLK_CYC(ENC_CLK_CYC)) i_link_checker (
    .sys_clk(sys_clk), .resetn(resetn), .transmit_request_n(transmit_request_n),
    .address_trit_inputs_oe_n(address_trit_inputs_oe_n),
    .address_or_data_trit_inputs_oe_n(address_or_data_trit_inputs_oe_n),
    .serial_out(serial_out), .encoder_busy(encoder_busy), .serial_in(serial_in),
    .decoded_nibble_outputs(decoded_nibble_outputs), .valid_word_flag(valid_word_flag));
`default_nettype wire

//--- trit_encoder.sv
/*
  trit_encoder: senses nine three-state pins and sends each word twice
  as pulse-width coded trits on one serial line.
  assumes raw pins on code_pin_in and transmit_request_n.
*/
`timescale 1ns/10ps
`default_nettype none
module trit_encoder #(
    parameter int ENC_CLK_CYC = tl_pkg::ENC_CLK_CYC,
    parameter int SETTLE_CYC  = tl_pkg::SETTLE_CYC
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // request and code pins
    input  wire logic       transmit_request_n,
    input  wire logic [8:0] code_pin_in,
    output logic      [8:0] code_pin_out,
    output logic      [8:0] code_pin_oe_n,
    // serial line
    output logic            serial_out,
    output logic            busy
);
    localparam tl_pkg::cnt_t BIT_CYC   = tl_pkg::cnt_t'(tl_pkg::BIT_CLKS * ENC_CLK_CYC);
    localparam tl_pkg::cnt_t SHORT_CYC = tl_pkg::cnt_t'(tl_pkg::SHORT_CLKS * ENC_CLK_CYC);
    localparam tl_pkg::cnt_t LONG_CYC  = tl_pkg::cnt_t'(tl_pkg::LONG_CLKS * ENC_CLK_CYC);
    localparam tl_pkg::cnt_t GAP_CYC   =
        tl_pkg::cnt_t'(tl_pkg::GAP_PERIODS * tl_pkg::PERIOD_CLKS * ENC_CLK_CYC);
    // probe flop and pin sync add four cycles
    localparam tl_pkg::cnt_t SETTLE    = tl_pkg::cnt_t'(SETTLE_CYC + 4);
    localparam logic [3:0]   LAST_POS  = 4'(tl_pkg::WORD_TRITS - 1);

    typedef enum logic [2:0] {E_IDLE, E_SENSE_HI, E_SENSE_LO, E_SEND, E_GAP} enc_state_t;

    logic [2:0] req_s_reg, req_s_next;
    logic       req_reg, req_next;
    logic [8:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_reg, pin_next;

    enc_state_t           state_reg, state_next;
    tl_pkg::cnt_t         cnt_reg, cnt_next;
    logic [3:0]           pos_reg, pos_next;
    logic                 half_reg, half_next;
    logic                 word_reg, word_next;
    logic                 hi_seen_reg, hi_seen_next;
    tl_pkg::trit_t [8:0]  trits_reg, trits_next;
    logic [8:0]           out_next, oe_n_next;
    logic                 ser_next, busy_next, long_bit;
    tl_pkg::trit_t        cur;

    // pin synchronisers: a change counts once stages two and three agree
    always_comb begin
        req_s_next = {req_s_reg[1:0], transmit_request_n};
        req_next   = (req_s_reg[1] == req_s_reg[2]) ? req_s_reg[2] : req_reg;
        pin_next   = (pin_s2_reg & pin_s3_reg) | (pin_reg & (pin_s2_reg ^ pin_s3_reg));
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            req_s_reg  <= 3'h7;
            req_reg    <= 1'h1;
            pin_s1_reg <= 9'h000;
            pin_s2_reg <= 9'h000;
            pin_s3_reg <= 9'h000;
            pin_reg    <= 9'h000;
        end else begin
            req_s_reg  <= req_s_next;
            req_reg    <= req_next;
            pin_s1_reg <= code_pin_in;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            pin_reg    <= pin_next;
        end
    end

    always_comb begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        pos_next     = pos_reg;
        half_next    = half_reg;
        word_next    = word_reg;
        hi_seen_next = hi_seen_reg;
        trits_next   = trits_reg;
        unique case (state_reg)
            E_IDLE: begin
                if (!req_reg) begin
                    state_next = E_SENSE_HI;
                    cnt_next   = '0;
                    pos_next   = 4'h0;
                    word_next  = 1'h0;
                end
            end
            E_SENSE_HI: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == SETTLE) begin
                    hi_seen_next = pin_reg[pos_reg];
                    cnt_next     = '0;
                    state_next   = E_SENSE_LO;
                end
            end
            E_SENSE_LO: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == SETTLE) begin
                    // both forceable: open; stays high: tied high; else tied low
                    if (hi_seen_reg && !pin_reg[pos_reg])
                        trits_next[pos_reg] = tl_pkg::TRIT_OPEN;
                    else if (pin_reg[pos_reg])
                        trits_next[pos_reg] = tl_pkg::TRIT_HIGH;
                    else
                        trits_next[pos_reg] = tl_pkg::TRIT_LOW;
                    cnt_next = '0;
                    if (pos_reg == LAST_POS) begin
                        pos_next   = 4'h0;
                        half_next  = 1'h0;
                        state_next = E_SEND;
                    end else begin
                        pos_next   = pos_reg + 4'h1;
                        state_next = E_SENSE_HI;
                    end
                end
            end
            E_SEND: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == BIT_CYC - 1'b1) begin
                    cnt_next  = '0;
                    half_next = ~half_reg;
                    if (half_reg && pos_reg == LAST_POS) begin
                        pos_next = 4'h0;
                        if (!word_reg) begin
                            state_next = E_GAP;
                            word_next  = 1'h1;
                        end else if (!req_reg) begin
                            state_next = E_GAP;
                            word_next  = 1'h0;
                        end else begin
                            state_next = E_IDLE;
                        end
                    end else if (half_reg) begin
                        pos_next = pos_reg + 4'h1;
                    end
                end
            end
            E_GAP: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == GAP_CYC - 1'b1) begin
                    cnt_next   = '0;
                    half_next  = 1'h0;
                    state_next = word_reg ? E_SEND : E_SENSE_HI;
                end
            end
        endcase
        // probe only the selected pin, weakly
        oe_n_next = 9'h1ff;
        out_next  = 9'h000;
        if (state_next == E_SENSE_HI || state_next == E_SENSE_LO) begin
            oe_n_next[pos_next] = 1'h0;
            out_next[pos_next]  = (state_next == E_SENSE_HI);
        end
        cur       = trits_next[pos_next];
        long_bit  = half_next ? (cur == tl_pkg::TRIT_HIGH) : (cur != tl_pkg::TRIT_LOW);
        ser_next  = (state_next == E_SEND) && (cnt_next < (long_bit ? LONG_CYC : SHORT_CYC));
        busy_next = (state_next != E_IDLE);
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_reg     <= E_IDLE;
            cnt_reg       <= '0;
            pos_reg       <= 4'h0;
            half_reg      <= 1'h0;
            word_reg      <= 1'h0;
            hi_seen_reg   <= 1'h0;
            trits_reg     <= '0;
            code_pin_out  <= 9'h000;
            code_pin_oe_n <= 9'h1ff;
            serial_out    <= 1'h0;
            busy          <= 1'h0;
        end else begin
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            pos_reg       <= pos_next;
            half_reg      <= half_next;
            word_reg      <= word_next;
            hi_seen_reg   <= hi_seen_next;
            trits_reg     <= trits_next;
            code_pin_out  <= out_next;
            code_pin_oe_n <= oe_n_next;
            serial_out    <= ser_next;
            busy          <= busy_next;
        end
    end
endmodule // trit_encoder
`default_nettype wire

//--- trit_word_sender.sv
/* trit_word_sender: far-end encoder model driving the decoder serial input.
   assumes the same encoder clock setting as the decoder under test. */
`timescale 1ns/10ps
`default_nettype none
module trit_word_sender #(
    parameter int ENC = 4
) (
    // clock
    input  wire logic sys_clk,
    // serial line towards the decoder
    output var logic  line
);
    initial line = 1'b0;
    // one word of nine trits, then the idle gap with the line low
    task automatic send_word(input logic [17:0] w);
        logic [1:0] t;
        int         hi;
        for (int k = 0; k < 18; k++) begin
            t = w[2*(k/2)+:2];
            hi = tl_pkg::SHORT_CLKS;
            if ((k % 2 == 0) ? (t != tl_pkg::TRIT_LOW) : (t == tl_pkg::TRIT_HIGH))
                hi = tl_pkg::LONG_CLKS;
            for (int c = 0; c < tl_pkg::BIT_CLKS * ENC; c++) begin
                @(posedge sys_clk);
                line <= (c < hi * ENC);
            end
        end
        repeat (tl_pkg::GAP_PERIODS * tl_pkg::PERIOD_CLKS * ENC) @(posedge sys_clk);
    endtask
endmodule // trit_word_sender
`default_nettype wire
